// [rtl/eppc_top.sv]
// Overview of operation
// - newer read stalls host until handshake allows
// - handshake low at strobe: finish when high
// - handshake high at start: wait low first
// - newer read: release bus, direction high, strobe
// - handshake high: capture byte, drop strobe
// - then ready sync, return byte, turnaround
// - idle bus follows standard control, direction
// - abort wait-low or strobe phase over 10 us, flag status
// - older write stalls while handshake low
// - older write drives byte, then strobe
// - older write finishes on release or timeout
// - older read releases bus, strobes, finishes
// - older read stalls while handshake low
// - active-low direction, separate data/address strobes
// - peripheral interrupt passes through uninverted
// - drive active-low peripheral reset output
// - only direction overridable by control strobe
// - offset 3 address, 4 to 7 data
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "eppc_map.svh"
module eppc_top import eppc_pkg::*; #(
  parameter int unsigned TMO_CYC = `EPPC_TMO_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            sync_wait_o,
  output logic            sync_ready_o,
  output logic      [7:0] xfer_byte_o,
  input  wire logic [7:0] port_byte_bus_i,
  output logic      [7:0] port_byte_bus_o,
  output logic            port_byte_bus_oe_o,
  input  wire logic       periph_handshake_n_i,
  input  wire logic       periph_irq_in_i,
  output logic            periph_irq_o,
  output logic            xfer_dir_out_n_o,
  output logic            data_phase_strobe_n_o,
  output logic            addr_phase_strobe_n_o,
  output logic            pad_direction_bit_o,
  output logic            periph_reset_out_n_o,
  output logic            strobe_n_o,
  output logic            autofd_n_o,
  output logic            init_n_o,
  output logic            slctin_n_o
);
  eppc_state_t state_q;
  eppc_state_t state_d;
  logic [9:0]  meta_q;
  logic [9:0]  sync_q;
  logic        hs_s;
  logic        irq_s;
  eppc_byte_t  port_byte_bus_s;
  eppc_byte_t  spp_data_q;
  logic [5:0]  ctl_q;
  logic [3:0]  cfg_q;
  logic        tmo_q;
  eppc_byte_t  wbyte_q;
  eppc_byte_t  xfer_byte_q;
  logic        cyc_wr_q;
  logic        cyc_addr_q;
  logic        cyc_old_q;
  logic        enh_sel;
  logic        launch;
  logic        tmo_hit;
  logic        tmo_set;
  logic        drive_cyc;
  logic        cyc_out;
  logic        idle_out;
  eppc_byte_t  rdata_q;
  eppc_byte_t  port_byte_bus_o_q;
  logic        port_byte_bus_oe_q;
  logic        dir_n_q;
  logic        pad_dir_q;
  logic        data_n_q;
  logic        addr_n_q;
  logic        sync_wait_q;
  logic        sync_ready_q;
  logic        irq_q;
  logic        prst_n_q;
  logic [3:0]  spp_out_q;

  eppc_wdt_if wdt_if ();

  eppc_wdt #(
    .TMO_CYC (TMO_CYC)
  ) u_wdt (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .wdt    (wdt_if)
  );

  // pins are asynchronous to clk: two stages before anything looks at them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 10'h3ff;
      sync_q <= 10'h3ff;
    end else begin
      meta_q <= {periph_irq_in_i, periph_handshake_n_i, port_byte_bus_i};
      sync_q <= meta_q;
    end
  end

  assign irq_s   = sync_q[9];
  assign hs_s    = sync_q[8];
  assign port_byte_bus_s = sync_q[7:0];

  assign enh_sel = (addr_i >= `EPPC_OFS_ADDR) && (addr_i <= `EPPC_OFS_DATA3);
  // enhanced offsets do nothing unless the enhanced mode is on
  assign launch  = cfg_q[`EPPC_CFG_EN] && (state_q == ST_IDLE) && (wr_i || rd_i) && enh_sel;
  assign tmo_hit = wdt_if.expired;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (launch) begin
          // newer flavour must see the handshake low before touching outputs
          if (!cfg_q[`EPPC_CFG_OLD] && hs_s) begin
            state_d = ST_WAIT_LOW;
          end else begin
            state_d = ST_SETUP;
          end
        end
      end
      ST_WAIT_LOW: begin
        if (tmo_hit) begin
          state_d = ST_FINISH;
        end else if (!hs_s) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_d = ST_STROBE;
      end
      ST_STROBE: begin
        // stall while handshake low, complete on release or timeout
        if (hs_s || tmo_hit) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cycle attributes frozen at launch so software writes mid-cycle cannot skew it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_wr_q   <= 1'b0;
      cyc_addr_q <= 1'b0;
      cyc_old_q  <= 1'b0;
      wbyte_q    <= `EPPC_RST_BYTE;
    end else if (launch) begin
      cyc_wr_q   <= wr_i;
      cyc_addr_q <= (addr_i == `EPPC_OFS_ADDR);
      cyc_old_q  <= cfg_q[`EPPC_CFG_OLD];
      if (wr_i) begin
        wbyte_q <= wdata_i;
      end
    end
  end

  assign wdt_if.restart = launch || ((state_d == ST_STROBE) && (state_q != ST_STROBE));
  assign wdt_if.arm     = (state_q == ST_WAIT_LOW) || (state_q == ST_SETUP) ||
                          (state_q == ST_STROBE);

  // older flavour: direction from software; launch edge reads the request itself
  assign drive_cyc = (state_d == ST_SETUP) || (state_d == ST_STROBE);
  assign cyc_out   = ((launch ? cfg_q[`EPPC_CFG_OLD] : cyc_old_q) ? !ctl_q[`EPPC_CTL_PCD] :
                      (launch ? wr_i : cyc_wr_q)) || ctl_q[`EPPC_CTL_STROBE];
  assign idle_out  = !cfg_q[`EPPC_CFG_BIDIR] || !ctl_q[`EPPC_CTL_PCD] ||
                     ctl_q[`EPPC_CTL_STROBE];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_byte_bus_o_q  <= `EPPC_RST_BYTE;
      port_byte_bus_oe_q <= 1'b1;
      dir_n_q    <= 1'b0;
      pad_dir_q  <= 1'b0;
    end else if (drive_cyc) begin
      port_byte_bus_o_q  <= (launch && wr_i) ? wdata_i : wbyte_q;
      port_byte_bus_oe_q <= cyc_out;
      dir_n_q    <= !cyc_out;
      pad_dir_q  <= !cyc_out;
    end else begin
      port_byte_bus_o_q  <= spp_data_q;
      port_byte_bus_oe_q <= idle_out;
      dir_n_q    <= !idle_out;
      pad_dir_q  <= !idle_out;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_n_q <= 1'b1;
      addr_n_q <= 1'b1;
    end else begin
      data_n_q <= !((state_d == ST_STROBE) && !cyc_addr_q);
      addr_n_q <= !((state_d == ST_STROBE) && cyc_addr_q);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xfer_byte_q <= `EPPC_RST_BYTE;
    end else if ((state_q == ST_STROBE) && (state_d == ST_FINISH) && !cyc_wr_q) begin
      xfer_byte_q <= port_byte_bus_s;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_wait_q  <= 1'b0;
      sync_ready_q <= 1'b0;
    end else begin
      sync_wait_q  <= drive_cyc || (state_d == ST_WAIT_LOW);
      sync_ready_q <= (state_d == ST_FINISH);
    end
  end

  // timeout is a real failure in the wait-low phase, or in the strobe phase if the handshake never released
  assign tmo_set = tmo_hit && ((state_q == ST_WAIT_LOW) || ((state_q == ST_STROBE) && !hs_s));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmo_q <= 1'b0;
    end else if (tmo_set) begin
      tmo_q <= 1'b1;
    end else if (wr_i && (addr_i == `EPPC_OFS_STATUS) && wdata_i[`EPPC_STS_TMO]) begin
      tmo_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spp_data_q <= `EPPC_RST_BYTE;
      ctl_q      <= `EPPC_RST_CTRL;
      cfg_q      <= `EPPC_RST_CFG;
    end else if (wr_i) begin
      if (addr_i == `EPPC_OFS_SPP_DATA) begin
        spp_data_q <= wdata_i;
      end
      if (addr_i == `EPPC_OFS_CTRL) begin
        ctl_q <= wdata_i[5:0];
      end
      if (addr_i == `EPPC_OFS_CONFIG) begin
        cfg_q <= wdata_i[3:0];
      end
    end
  end

  // enhanced reads answer at once with the last captured byte; the fresh byte
  // arrives on xfer_byte_o together with the ready sync
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= `EPPC_RST_BYTE;
    end else if (rd_i) begin
      if (addr_i == `EPPC_OFS_SPP_DATA) begin
        rdata_q <= idle_out ? spp_data_q : port_byte_bus_s;
      end else if (addr_i == `EPPC_OFS_STATUS) begin
        rdata_q <= {5'h00, hs_s, (state_q != ST_IDLE), tmo_q};
      end else if (addr_i == `EPPC_OFS_CTRL) begin
        rdata_q <= {2'b00, ctl_q};
      end else if (enh_sel) begin
        rdata_q <= cfg_q[`EPPC_CFG_EN] ? xfer_byte_q : 8'h00;
      end else if (addr_i == `EPPC_OFS_CONFIG) begin
        rdata_q <= {4'h0, cfg_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q     <= 1'b0;
      prst_n_q  <= 1'b1;
      spp_out_q <= 4'hf;
    end else begin
      irq_q     <= irq_s && ctl_q[`EPPC_CTL_IRQE];
      prst_n_q  <= !cfg_q[`EPPC_CFG_PRST];
      spp_out_q <= {!ctl_q[`EPPC_CTL_SLCTIN], ctl_q[`EPPC_CTL_INIT],
                    !ctl_q[`EPPC_CTL_AUTOFD], !ctl_q[`EPPC_CTL_STROBE]};
    end
  end

  assign rdata_o               = rdata_q;
  assign sync_wait_o           = sync_wait_q;
  assign sync_ready_o          = sync_ready_q;
  assign xfer_byte_o           = xfer_byte_q;
  assign port_byte_bus_o       = port_byte_bus_o_q;
  assign port_byte_bus_oe_o    = port_byte_bus_oe_q;
  assign periph_irq_o          = irq_q;
  assign xfer_dir_out_n_o      = dir_n_q;
  assign data_phase_strobe_n_o = data_n_q;
  assign addr_phase_strobe_n_o = addr_n_q;
  assign pad_direction_bit_o   = pad_dir_q;
  assign periph_reset_out_n_o  = prst_n_q;
  assign strobe_n_o            = spp_out_q[0];
  assign autofd_n_o            = spp_out_q[1];
  assign init_n_o              = spp_out_q[2];
  assign slctin_n_o            = spp_out_q[3];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_strobe_exclusive: assert property (data_n_q || addr_n_q)
    else $error("both strobes low");
  a_wait_low_hold: assert property ((state_q == ST_WAIT_LOW) && hs_s && !tmo_hit
    |=> data_n_q && addr_n_q && (state_q == ST_WAIT_LOW))
    else $error("strobe moved before handshake low");
  a_read_dir_set: assert property ((!data_n_q || !addr_n_q) && !cyc_wr_q && !cyc_old_q &&
    !ctl_q[`EPPC_CTL_STROBE] |-> !port_byte_bus_oe_q && dir_n_q && pad_dir_q)
    else $error("newer read strobe without released bus");
  a_read_stall: assert property ((state_q == ST_STROBE) && !hs_s && !tmo_hit
    |=> !sync_ready_q && sync_wait_q && (!data_n_q || !addr_n_q))
    else $error("read finished while handshake low");
  a_capture_byte: assert property ((state_q == ST_STROBE) && hs_s && !cyc_wr_q
    |=> (xfer_byte_q == $past(port_byte_bus_s)) && data_n_q && addr_n_q)
    else $error("byte not captured at termination");
  a_ready_pulse: assert property ($rose(sync_ready_q)
    |-> !sync_wait_q ##1 !sync_ready_q && (state_q == ST_IDLE))
    else $error("ready sync not a single pulse");
  a_old_write_drive: assert property ((state_q == ST_STROBE) && cyc_wr_q && cyc_old_q &&
    !ctl_q[`EPPC_CTL_PCD] |-> port_byte_bus_oe_q && !dir_n_q && (port_byte_bus_o_q == wbyte_q))
    else $error("older write strobe without byte on bus");
  a_tmo_flag: assert property (tmo_set |=> tmo_q && sync_ready_q)
    else $error("timeout not flagged");
  a_no_hang: assert property ($rose(sync_wait_q) |-> ##[1:520] sync_ready_q)
    else $error("host cycle never ended");
  a_strobe_setup: assert property ($fell(data_n_q) || $fell(addr_n_q)
    |-> $past(state_q) == ST_SETUP)
    else $error("strobe without setup cycle");
  a_irq_pass: assert property (ctl_q[`EPPC_CTL_IRQE] && $stable(ctl_q)
    |=> irq_q == $past(irq_s))
    else $error("interrupt not passed through");

  c_newer_read: cover property (!cyc_old_q && !cyc_wr_q && $rose(sync_ready_q) && !tmo_q);
  c_older_write: cover property (cyc_old_q && cyc_wr_q && $rose(sync_ready_q));
  c_timeout: cover property (tmo_set);
  c_wait_low: cover property ((state_q == ST_WAIT_LOW) ##1 (state_q == ST_SETUP));
endmodule
`default_nettype wire

// [rtl/eppc_map.svh]
`ifndef EPPC_MAP_SVH
`define EPPC_MAP_SVH
`define EPPC_OFS_SPP_DATA 4'h0
`define EPPC_OFS_STATUS   4'h1
`define EPPC_OFS_CTRL     4'h2
`define EPPC_OFS_ADDR     4'h3
`define EPPC_OFS_DATA0    4'h4
`define EPPC_OFS_DATA3    4'h7
`define EPPC_OFS_CONFIG   4'h8
`define EPPC_CTL_STROBE   0
`define EPPC_CTL_AUTOFD   1
`define EPPC_CTL_INIT     2
`define EPPC_CTL_SLCTIN   3
`define EPPC_CTL_IRQE     4
`define EPPC_CTL_PCD      5
`define EPPC_STS_TMO      0
`define EPPC_STS_BUSY     1
`define EPPC_STS_HS       2
`define EPPC_CFG_EN       0
`define EPPC_CFG_OLD      1
`define EPPC_CFG_BIDIR    2
`define EPPC_CFG_PRST     3
`define EPPC_RST_CTRL     6'h00
`define EPPC_RST_CFG      4'h0
`define EPPC_RST_BYTE     8'h00
`define EPPC_CLK_NS       20
`define EPPC_TMO_NS       10000
`define EPPC_TMO_CYC      (`EPPC_TMO_NS / `EPPC_CLK_NS)
`endif

// [rtl/eppc_pkg.sv]
package eppc_pkg;
  typedef logic [7:0] eppc_byte_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_LOW,
    ST_SETUP,
    ST_STROBE,
    ST_FINISH
  } eppc_state_t;
endpackage

// [rtl/eppc_wdt_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface eppc_wdt_if;
  logic restart;
  logic arm;
  logic expired;
  modport eng (output restart, output arm, input expired);
  modport wdt (input restart, input arm, output expired);
endinterface
`default_nettype wire

// [rtl/eppc_wdt.sv]
`timescale 1ns/1ns
`default_nettype none
`include "eppc_map.svh"
module eppc_wdt import eppc_pkg::*; #(
  parameter int unsigned TMO_CYC = `EPPC_TMO_CYC,
  parameter int unsigned CNT_W   = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  eppc_wdt_if.wdt  wdt
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TMO_CYC - 1);

  logic [CNT_W-1:0] count_q;
  logic             run_q;
  logic             expired_q;

  generate
    if (TMO_CYC < 2 || TMO_CYC >= (2 ** CNT_W)) begin : g_bad_cfg
      $error("eppc_wdt: TMO_CYC does not fit the counter");
    end
  endgenerate

  // count restarts on every restart pulse, so each strobe gets a full window
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= '0;
      run_q   <= 1'b0;
    end else if (wdt.restart) begin
      count_q <= '0;
      run_q   <= 1'b1;
    end else if (!wdt.arm) begin
      run_q   <= 1'b0;
    end else if (run_q) begin
      if (count_q == LAST) begin
        run_q <= 1'b0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= run_q && wdt.arm && !wdt.restart && (count_q == LAST);
    end
  end

  assign wdt.expired = expired_q;
endmodule
`default_nettype wire

// [tb/eppc_periph.sv]
`timescale 1ns/1ns
`default_nettype none
module eppc_periph (
  input  wire logic       clk_i,
  input  wire logic       data_stb_n_i,
  input  wire logic       addr_stb_n_i,
  input  wire logic       dir_n_i,
  input  wire logic [7:0] bus_i,
  input  wire logic [7:0] rd_byte_i,
  input  wire logic [2:0] delay_i,
  input  wire logic [2:0] linger_i,
  input  wire logic       stall_i,
  output logic            hs_n_o,
  output logic      [7:0] bus_o,
  output logic            bus_oe_o,
  output logic      [7:0] got_o
);
  logic [2:0] cnt_q;
  initial begin
    hs_n_o = 1'b0;
    bus_oe_o = 1'b0;
    cnt_q = 3'h0;
    bus_o = 8'h5a;
    got_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (!data_stb_n_i || !addr_stb_n_i) begin
      if (cnt_q != delay_i) begin
        cnt_q <= cnt_q + 3'h1;
      end else if (stall_i) begin
        bus_o <= ~bus_o;
      end else if (dir_n_i && !bus_oe_o) begin
        bus_oe_o <= 1'b1; // data goes out a cycle before the ack
        bus_o <= rd_byte_i;
      end else begin
        hs_n_o <= 1'b1;
        if (!dir_n_i) got_o <= bus_i;
      end
    end else begin
      // released bus keeps moving so a stale byte can never be captured
      bus_oe_o <= 1'b0;
      bus_o <= ~bus_o;
      if (hs_n_o && cnt_q == linger_i) begin
        hs_n_o <= 1'b0;
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= hs_n_o ? cnt_q + 3'h1 : 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/test_enhanced_parallel_port_cycles.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_enhanced_parallel_port_cycles;
  localparam int TMO = 20;
  logic            clk_i, rstn_i, wr_i, rd_i, irq_i, stall, old_fl;
  logic      [3:0] addr_i;
  logic      [7:0] wdata_i, rdata_o, xbyte, bus_o, per_bus, per_rd, per_got;
  logic            wait_o, ready_o, oe, dir_n, dstb_n, astb_n, pad, prst_n, irq_o, hs_n, per_oe;
  logic      [2:0] dly, lng;
  wire logic [3:0] ctl_n;
  wire logic [7:0] bus_in = oe ? bus_o : per_bus;
  int              num_errors, num_checks, seed;

  eppc_top #(.TMO_CYC(TMO)) u_eppc_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sync_wait_o(wait_o), .sync_ready_o(ready_o),
    .xfer_byte_o(xbyte), .port_byte_bus_i(bus_in), .port_byte_bus_o(bus_o),
    .port_byte_bus_oe_o(oe), .periph_handshake_n_i(hs_n), .periph_irq_in_i(irq_i),
    .periph_irq_o(irq_o), .xfer_dir_out_n_o(dir_n), .data_phase_strobe_n_o(dstb_n),
    .addr_phase_strobe_n_o(astb_n), .pad_direction_bit_o(pad), .periph_reset_out_n_o(prst_n),
    .strobe_n_o(ctl_n[3]), .autofd_n_o(ctl_n[2]), .init_n_o(ctl_n[1]), .slctin_n_o(ctl_n[0]));
  eppc_periph u_eppc_periph (
    .clk_i(clk_i), .data_stb_n_i(dstb_n), .addr_stb_n_i(astb_n), .dir_n_i(dir_n),
    .bus_i(bus_in), .rd_byte_i(per_rd), .delay_i(dly), .linger_i(lng), .stall_i(stall),
    .hs_n_o(hs_n), .bus_o(per_bus), .bus_oe_o(per_oe), .got_o(per_got));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task put(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task get(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("read data", e, rdata_o)
    @(posedge clk_i);
  endtask

  task cyc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic dn,
           input logic tmo);
    int   n;
    logic low, stb;
    n = 0;
    low = 1'b0;
    stb = 1'b0;
    // older flavour has no wait-low phase: let the peer signal ready first
    while (old_fl && hs_n !== 1'b0) begin
      @(posedge clk_i);
      #1;
    end
    per_rd <= d;
    put(w, a, d);
    #1;
    while (ready_o !== 1'b1 && n < 4 * TMO + 60) begin
      `CHK("wait sync", 1'b1, wait_o)
      low = low | !hs_n;
      `CHK("bus contention", 1'b0, oe && per_oe)
      if (!(dstb_n && astb_n)) begin
        if (!stb) `CHK("ready before strobe", 1'b1, low)
        stb = 1'b1;
        `CHK("strobe kind", (a == 4'h3) ? 2'b10 : 2'b01, {dstb_n, astb_n})
        `CHK("direction", {dn, !dn, dn}, {dir_n, oe, pad})
        if (w) `CHK("bus drive", d, bus_o)
      end
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK("ready sync", 1'b1, ready_o)
    `CHK("end state", 3'b110, {dstb_n, astb_n, wait_o})
    `CHK("strobe seen", 1'b1, stb)
    `CHK("ack at end", !tmo, hs_n)
    if (tmo) `CHK("timeout span", 1'b1, n >= TMO)
    else if (w) `CHK("peer byte", d, per_got)
    else if (dn) `CHK("read byte", d, xbyte)
    @(posedge clk_i);
    #1;
    `CHK("ready pulse", 1'b0, ready_o)
  endtask

  initial begin
    logic w;
    {wr_i, rd_i, irq_i, stall, rstn_i, old_fl} = 6'h00;
    {addr_i, wdata_i, per_rd, dly, lng} = 26'h0;
    num_errors = 0;
    num_checks = 0;
    seed = $urandom(76);
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    `CHK("idle strobes", 3'b110, {dstb_n, astb_n, wait_o})
    `CHK("periph reset", 1'b1, prst_n)
    put(1'b1, 4'h8, 8'h08);
    `CHK("periph reset", 1'b0, prst_n)
    put(1'b1, 4'h8, 8'h00);
    put(1'b1, 4'h0, 8'ha5);
    put(1'b1, 4'h2, 8'h0f);
    `CHK("idle out", {8'ha5, 3'b100, 4'b0010}, {bus_o, oe, dir_n, pad, ctl_n})
    get(4'h2, 8'h0f);
    put(1'b1, 4'h8, 8'h04);
    put(1'b1, 4'h2, 8'h20);
    `CHK("idle in", 3'b011, {oe, dir_n, pad})
    put(1'b0, 4'h4, 8'h00);
    `CHK("disabled", 1'b0, wait_o)
    get(4'h5, 8'h00);
    get(4'hc, 8'h00);
    put(1'b1, 4'h2, 8'h10);
    irq_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("irq pass", 1'b1, irq_o)
    put(1'b1, 4'h2, 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("irq masked", 1'b0, irq_o)
    irq_i <= 1'b0;
    put(1'b1, 4'h8, 8'h05);
    repeat (30) begin
      w = 1'($urandom);
      dly <= 3'($urandom);
      lng <= 3'($urandom);
      cyc(w, 4'h3 + 4'($urandom % 5), 8'($urandom), !w, 1'b0);
    end
    lng <= 3'h7;
    dly <= 3'h0;
    cyc(1'b0, 4'h3, 8'hff, 1'b1, 1'b0);
    cyc(1'b1, 4'h7, 8'h00, 1'b0, 1'b0);
    lng <= 3'h0;
    put(1'b1, 4'h8, 8'h07);
    old_fl = 1'b1;
    repeat (10) begin
      w = 1'($urandom);
      dly <= 3'($urandom);
      put(1'b1, 4'h2, w ? 8'h00 : 8'h20);
      cyc(w, 4'h3 + 4'($urandom % 5), 8'($urandom), !w, 1'b0);
    end
    put(1'b1, 4'h2, 8'h21);
    cyc(1'b0, 4'h4, 8'h3c, 1'b0, 1'b0);
    put(1'b1, 4'h2, 8'h20);
    stall <= 1'b1;
    cyc(1'b0, 4'h4, 8'h11, 1'b1, 1'b1);
    get(4'h1, 8'h01);
    stall <= 1'b0;
    put(1'b1, 4'h1, 8'h01);
    get(4'h1, 8'h00);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
